// [tpu_defines.vh]
// register map, field positions, reset values, lfsr seed and response codes for the timer/pwm unit
// assumes: included by the unit's design files, 32-bit axi4-lite register access
`ifndef TPU_DEFINES_VH
`define TPU_DEFINES_VH

`define TPU_ADDR_W        6
`define TPU_OFS_CTRL      6'h00
`define TPU_OFS_DIV       6'h04
`define TPU_OFS_PERIOD    6'h08
`define TPU_OFS_CMP       6'h0c
`define TPU_OFS_DEAD      6'h10
`define TPU_OFS_COUNT     6'h14
`define TPU_OFS_CAPTURE   6'h18
`define TPU_OFS_STATUS    6'h1c
`define TPU_OFS_INT_EN    6'h20
`define TPU_OFS_INT_CLR   6'h24
`define TPU_OFS_STATE     6'h28

`define TPU_CTRL_RUN      0
`define TPU_CTRL_ONESHOT  1
`define TPU_CTRL_MODE_LO  2
`define TPU_CTRL_MODE_HI  3
`define TPU_CTRL_CAP_EN   4
`define TPU_CTRL_CAP_RISE 5
`define TPU_CTRL_KILL_CMP 6
`define TPU_CTRL_KILL_PIN 7
`define TPU_CTRL_SAFE_P   8
`define TPU_CTRL_SAFE_N   9
`define TPU_CTRL_KILL_STK 10
`define TPU_CTRL_W        11

`define TPU_MODE_EDGE     2'h0
`define TPU_MODE_CENTER   2'h1
`define TPU_MODE_PRAND    2'h2

`define TPU_EV_TC         0
`define TPU_EV_CMP        1
`define TPU_EV_CAP        2
`define TPU_EV_KILL       3
`define TPU_EV_W          4

`define TPU_RST_CTRL      11'h000
`define TPU_RST_DIV       16'h0000
`define TPU_RST_PERIOD    16'hffff
`define TPU_RST_CMP       16'h8000
`define TPU_RST_DEAD      8'h00
`define TPU_LFSR_SEED     16'hace1

`define TPU_RESP_OKAY     2'h0
`define TPU_RESP_SLVERR   2'h2

`endif

// [tpu_sync.v]
// three-flop synchroniser for a pin input, change counted when flops two and three agree
// assumes: single clock clk_i, synchronous active-high reset
`default_nettype none
module tpu_sync (
  input  wire clk_i,
  input  wire reset_i,
  input  wire pin_i,
  output reg  level_o
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  always @(posedge clk_i) begin
    if (reset_i) begin
      s1_reg  <= 1'b0;
      s2_reg  <= 1'b0;
      s3_reg  <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // only flops two and three are compared
      if (s2_reg == s3_reg) begin
        level_o <= s3_reg;
      end
    end
  end
endmodule
`default_nettype wire

// [tpu_prescaler.v]
// 16-bit divider of the cpu clock, one-cycle tick every div+1 clocks
// assumes: div_i comes from a register on the same clock
`include "tpu_defines.vh"
`default_nettype none
module tpu_prescaler (
  input  wire        clk_i,
  input  wire        reset_i,
  input  wire        run_i,
  input  wire [15:0] div_i,
  output reg         tick_o
);
  reg [15:0] cnt_reg;

  always @(posedge clk_i) begin
    if (reset_i || !run_i) begin
      cnt_reg <= 16'h0000;
      tick_o  <= 1'b0;
    end else if (cnt_reg >= div_i) begin
      cnt_reg <= 16'h0000;
      tick_o  <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
      tick_o  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [tpu_top.v]
// timer/counter/pwm unit with an axi4-lite register slave
// assumes: one clock clk_i, synchronous reset; capture and kill pins are asynchronous
//
// What this block does
// R01: a 16-bit counter whose period length software programs
// R02: counter ticks from a 16-bit divider of the cpu clock
// R03: capture event, possibly from a pin, copies counter into capture register
// R04: counter at period end (equal to period, or back at zero in center mode) either stops or reloads, as configured
// R05: compare register against counter (against the lfsr in pseudo-random mode) sets the pwm duty cycle
// R06: true and complement outputs separated by programmable dead time
// R07: kill input forces both outputs to a safe state together, some clocks after the pin through its synchroniser and the output register
// R08: edge-aligned, center-aligned and pseudo-random pwm modes
// R09: comparator output can trigger kill for over-current shutdown
// R10: counter advances one per divided tick while running, holds when stopped
`include "tpu_defines.vh"
`default_nettype none
module tpu_top (
  // clock and reset
  input  wire        clk_i,
  input  wire        reset_i,
  // axi4-lite write
  input  wire [5:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read
  input  wire [5:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // pins
  input  wire        capture_i,
  input  wire        kill_i,
  input  wire        comp_out_i,
  output reg         pwm_o,
  output reg         pwm_n_o,
  output reg         irq_o
);

  // registers
  reg [10:0] ctrl_reg;
  reg [15:0] div_reg;
  reg [15:0] period_reg;
  reg [15:0] cmp_reg;
  reg [7:0]  dead_reg;
  reg [15:0] count_reg;
  reg [15:0] capture_reg;
  reg [3:0]  status_reg;
  reg [3:0]  int_en_reg;
  reg        dir_down_reg;
  reg [15:0] lfsr_reg;
  reg        cap_prev_reg;
  reg        pwm_raw_reg;
  reg        raw_prev_reg;
  reg [7:0]  dead_cnt_reg;
  reg        kill_latch_reg;

  // axi state
  reg        aw_have_reg;
  reg        w_have_reg;
  reg [5:0]  aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0]  w_strb_reg;

  wire       cap_sync;
  wire       kill_sync;
  wire       comp_sync;
  wire       tick;
  wire [1:0] mode = ctrl_reg[`TPU_CTRL_MODE_HI:`TPU_CTRL_MODE_LO];
  wire       run  = ctrl_reg[`TPU_CTRL_RUN];

  tpu_sync u_sync_cap  (.clk_i(clk_i), .reset_i(reset_i), .pin_i(capture_i),  .level_o(cap_sync));
  tpu_sync u_sync_kill (.clk_i(clk_i), .reset_i(reset_i), .pin_i(kill_i),     .level_o(kill_sync));
  tpu_sync u_sync_comp (.clk_i(clk_i), .reset_i(reset_i), .pin_i(comp_out_i), .level_o(comp_sync));

  tpu_prescaler u_div ( // see R02
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .run_i   (run),
    .div_i   (div_reg),
    .tick_o  (tick)
  );

  // byte-lane merge for a 32-bit write onto a register of any width
  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer i;
    begin
      wmerge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          wmerge[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  // kill sources, level sensitive
  wire kill_now = (ctrl_reg[`TPU_CTRL_KILL_PIN] && kill_sync) ||
                  (ctrl_reg[`TPU_CTRL_KILL_CMP] && comp_sync); // see R09
  wire killed   = kill_now || kill_latch_reg;

  // counter events
  wire at_period = (count_reg == period_reg);
  wire tc_ev     = run && tick && (mode == `TPU_MODE_CENTER ? (dir_down_reg && count_reg == 16'h0000)
                                                            : at_period);
  wire cap_edge  = ctrl_reg[`TPU_CTRL_CAP_RISE] ? (cap_sync && !cap_prev_reg)
                                                : (!cap_sync && cap_prev_reg);
  wire cap_ev    = ctrl_reg[`TPU_CTRL_CAP_EN] && cap_edge;
  wire cmp_ev    = run && tick && (count_reg == cmp_reg);

  // duty decision
  reg  pwm_next;
  always @* begin
    case (mode)
      `TPU_MODE_CENTER: pwm_next = (count_reg < cmp_reg);
      `TPU_MODE_PRAND:  pwm_next = (lfsr_reg < cmp_reg);
      default:          pwm_next = (count_reg < cmp_reg);
    endcase
  end

  // axi write handling
  wire do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
  wire [31:0] wd = w_data_reg;

  always @(posedge clk_i) begin
    if (reset_i) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TPU_RESP_OKAY;
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      aw_addr_reg   <= 6'h00;
      w_data_reg    <= 32'h00000000;
      w_strb_reg    <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg   <= 1'b1;
        aw_addr_reg   <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg   <= 1'b1;
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        if (aw_addr_reg[5:2] <= `TPU_OFS_STATE >> 2) begin
          s_axi_bresp <= `TPU_RESP_OKAY;
        end else begin
          s_axi_bresp <= `TPU_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  wire wr_ctrl   = do_write && aw_addr_reg == `TPU_OFS_CTRL;
  wire wr_count  = do_write && aw_addr_reg == `TPU_OFS_COUNT;
  wire wr_intclr = do_write && aw_addr_reg == `TPU_OFS_INT_CLR;
  wire [31:0] ctrl_merged = wmerge({21'h000000, ctrl_reg}, wd, w_strb_reg);
  wire [31:0] div_merged  = wmerge({16'h0000, div_reg}, wd, w_strb_reg);

  // configuration registers
  always @(posedge clk_i) begin
    if (reset_i) begin
      ctrl_reg   <= `TPU_RST_CTRL;
      div_reg    <= `TPU_RST_DIV;
      period_reg <= `TPU_RST_PERIOD;
      cmp_reg    <= `TPU_RST_CMP;
      dead_reg   <= `TPU_RST_DEAD;
      int_en_reg <= 4'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= ctrl_merged[10:0];
      end else if (tc_ev && ctrl_reg[`TPU_CTRL_ONESHOT]) begin
        ctrl_reg[`TPU_CTRL_RUN] <= 1'b0; // see R04
      end
      if (do_write && aw_addr_reg == `TPU_OFS_DIV) begin
        div_reg <= div_merged[15:0];
      end
      if (do_write && aw_addr_reg == `TPU_OFS_PERIOD) begin
        period_reg <= wd[15:0]; // see R01
      end
      if (do_write && aw_addr_reg == `TPU_OFS_CMP) begin
        cmp_reg <= wd[15:0];
      end
      if (do_write && aw_addr_reg == `TPU_OFS_DEAD) begin
        dead_reg <= wd[7:0];
      end
      if (do_write && aw_addr_reg == `TPU_OFS_INT_EN) begin
        int_en_reg <= wd[3:0];
      end
    end
  end

  // counter, direction and pseudo-random source
  always @(posedge clk_i) begin
    if (reset_i) begin
      count_reg    <= 16'h0000;
      dir_down_reg <= 1'b0;
      lfsr_reg     <= `TPU_LFSR_SEED;
      cap_prev_reg <= 1'b0;
      capture_reg  <= 16'h0000;
    end else begin
      cap_prev_reg <= cap_sync;
      if (cap_ev) begin
        capture_reg <= count_reg; // see R03
      end
      if (wr_count) begin
        count_reg <= wd[15:0];
      end else if (run && tick) begin // see R10
        if (mode == `TPU_MODE_CENTER) begin // see R08
          if (!dir_down_reg) begin
            if (at_period) begin
              dir_down_reg <= 1'b1;
              count_reg    <= count_reg - 16'h0001;
            end else begin
              count_reg <= count_reg + 16'h0001;
            end
          end else if (count_reg == 16'h0000) begin
            dir_down_reg <= 1'b0;
            if (!ctrl_reg[`TPU_CTRL_ONESHOT]) begin
              count_reg <= 16'h0001;
            end
          end else begin
            count_reg <= count_reg - 16'h0001;
          end
        end else if (at_period) begin
          // one-shot halts on the period value instead of reloading
          if (!ctrl_reg[`TPU_CTRL_ONESHOT]) begin
            count_reg <= 16'h0000; // see R04
          end
        end else begin
          count_reg <= count_reg + 16'h0001; // see R01
        end
        lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
      end
    end
  end

  // pwm with dead band and kill
  always @(posedge clk_i) begin
    if (reset_i) begin
      pwm_raw_reg    <= 1'b0;
      raw_prev_reg   <= 1'b0;
      dead_cnt_reg   <= 8'h00;
      kill_latch_reg <= 1'b0;
      pwm_o          <= 1'b0;
      pwm_n_o        <= 1'b0;
    end else begin
      pwm_raw_reg  <= run ? pwm_next : 1'b0; // see R05
      raw_prev_reg <= pwm_raw_reg;
      // sticky kill holds until software rewrites ctrl
      if (wr_ctrl) begin
        kill_latch_reg <= 1'b0;
      end else if (kill_now && ctrl_reg[`TPU_CTRL_KILL_STK]) begin
        kill_latch_reg <= 1'b1;
      end
      if (pwm_raw_reg != raw_prev_reg) begin
        dead_cnt_reg <= dead_reg; // see R06
      end else if (dead_cnt_reg != 8'h00) begin
        dead_cnt_reg <= dead_cnt_reg - 8'h01;
      end
      if (killed) begin
        pwm_o   <= ctrl_reg[`TPU_CTRL_SAFE_P]; // see R07
        pwm_n_o <= ctrl_reg[`TPU_CTRL_SAFE_N];
      end else if (pwm_raw_reg != raw_prev_reg || dead_cnt_reg != 8'h00) begin
        pwm_o   <= 1'b0; // both off during dead time, see R06
        pwm_n_o <= 1'b0;
      end else begin
        pwm_o   <= pwm_raw_reg;
        pwm_n_o <= !pwm_raw_reg;
      end
    end
  end

  // sticky status, set wins over clear
  wire [3:0] ev_vec = {kill_now, cap_ev, cmp_ev, tc_ev};
  always @(posedge clk_i) begin
    if (reset_i) begin
      status_reg <= 4'h0;
      irq_o      <= 1'b0;
    end else begin
      status_reg <= (status_reg & ~(wr_intclr ? wd[3:0] : 4'h0)) | ev_vec;
      irq_o      <= |(status_reg & int_en_reg);
    end
  end

  // axi read
  reg [31:0] rd_mux;
  reg        rd_err;
  always @* begin
    rd_mux = 32'h00000000;
    rd_err = 1'b0;
    if (s_axi_araddr == `TPU_OFS_CTRL) begin
      rd_mux = {21'h000000, ctrl_reg};
    end else if (s_axi_araddr == `TPU_OFS_DIV) begin
      rd_mux = {16'h0000, div_reg};
    end else if (s_axi_araddr == `TPU_OFS_PERIOD) begin
      rd_mux = {16'h0000, period_reg};
    end else if (s_axi_araddr == `TPU_OFS_CMP) begin
      rd_mux = {16'h0000, cmp_reg};
    end else if (s_axi_araddr == `TPU_OFS_DEAD) begin
      rd_mux = {24'h000000, dead_reg};
    end else if (s_axi_araddr == `TPU_OFS_COUNT) begin
      rd_mux = {16'h0000, count_reg};
    end else if (s_axi_araddr == `TPU_OFS_CAPTURE) begin
      rd_mux = {16'h0000, capture_reg};
    end else if (s_axi_araddr == `TPU_OFS_STATUS) begin
      rd_mux = {28'h0000000, status_reg};
    end else if (s_axi_araddr == `TPU_OFS_INT_EN) begin
      rd_mux = {28'h0000000, int_en_reg};
    end else if (s_axi_araddr == `TPU_OFS_INT_CLR) begin
      rd_mux = 32'h00000000;
    end else if (s_axi_araddr == `TPU_OFS_STATE) begin
      rd_mux = {28'h0000000, killed, kill_latch_reg, dir_down_reg, pwm_raw_reg};
    end else begin
      rd_err = 1'b1;
    end
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `TPU_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_err ? `TPU_RESP_SLVERR : `TPU_RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// [tpu_chk_asserts.sv]
// port-level checker for the timer/pwm unit
// assumes: one clock, sync active-high reset, bench writes whole words
`include "tpu_defines.vh"
`default_nettype none
module tpu_chk (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        reset_i,
  // bus
  input wire logic [5:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [5:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // pins
  input wire logic        kill_i,
  input wire logic        comp_out_i,
  input wire logic        pwm_o,
  input wire logic        pwm_n_o,
  input wire logic        irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0]  a_q;
  logic [10:0] w_q;
  logic [10:0] ctrl_q;
  // shadow of ctrl; lags the design, so never disable kill while it is high
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      a_q    <= 6'h00;
      w_q    <= 11'h000;
      ctrl_q <= 11'h000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) a_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) w_q <= s_axi_wdata[10:0];
      if (s_axi_bvalid && s_axi_bready && a_q == `TPU_OFS_CTRL) ctrl_q <= w_q;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  reset_idle_a: assert property ($fell(reset_i) |-> !pwm_o && !pwm_n_o && !irq_o)
    else $error("outputs not idle after reset");
  overlap_free_a: assert property (!(pwm_o && pwm_n_o))
    else $error("both gate outputs high");
  kill_pin_safe_a: assert property ((kill_i && ctrl_q[7]) [*8] |->
    pwm_o == ctrl_q[8] && pwm_n_o == ctrl_q[9]) else $error("kill pin left outputs live");
  kill_comp_safe_a: assert property ((comp_out_i && ctrl_q[6]) [*8] |->
    pwm_o == ctrl_q[8] && pwm_n_o == ctrl_q[9]) else $error("comparator kill ignored");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  unmapped_err_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 6'h28
    |=> s_axi_rresp == `TPU_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad unmapped read");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  busy_ready_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write taken while answer pending");
endmodule
bind tpu_top tpu_chk u_chk (
  .clk_i(clk_i), .reset_i(reset_i), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .kill_i(kill_i), .comp_out_i(comp_out_i), .pwm_o(pwm_o), .pwm_n_o(pwm_n_o), .irq_o(irq_o)
);
`default_nettype wire

// [tpu_load_model.sv]
// load model: sums high time of the two gate drive pins
// assumes: sampled on the unit's clock, cleared by the bench before a window
`default_nettype none
module tpu_load_model (
  // clock and control
  input  wire logic        clk_i,
  input  wire logic        clr_i,
  // gate drives
  input  wire logic        pwm_i,
  input  wire logic        pwm_n_i,
  // high time in clocks
  output var  logic [15:0] hi_p_o,
  output var  logic [15:0] hi_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // sums, not edge times: duty and dead time both show up in them
  always_ff @(posedge clk_i) begin
    if (clr_i) begin
      hi_p_o <= 16'h0000;
      hi_n_o <= 16'h0000;
    end else begin
      hi_p_o <= hi_p_o + {15'h0000, pwm_i};
      hi_n_o <= hi_n_o + {15'h0000, pwm_n_i};
    end
  end
endmodule
`default_nettype wire

// [testbench.sv]
// self-checking bench for the timer/pwm unit, register tests over the bus
// assumes: design files, checker and load model compiled first
`include "tpu_defines.vh"
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin errors++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, reset_i = 1'b1, capture_i = 1'b0, kill_i = 1'b0, comp_out_i = 1'b0;
  logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, clr = 1'b1;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, pwm_o, pwm_n_o, irq_o;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] hi_p, hi_n;
  logic [31:0] c1, c2;
  logic [1:0] bresp_q, rresp_q;
  int errors = 0, checked = 0, cyc = 0;
  tpu_top u_dut (.clk_i(clk_i), .reset_i(reset_i), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .capture_i(capture_i), .kill_i(kill_i),
    .comp_out_i(comp_out_i), .pwm_o(pwm_o), .pwm_n_o(pwm_n_o), .irq_o(irq_o));
  tpu_load_model u_load (.clk_i(clk_i), .clr_i(clr), .pwm_i(pwm_o), .pwm_n_i(pwm_n_o),
    .hi_p_o(hi_p), .hi_n_o(hi_n));
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // s delays the response ready, to hold the slave's answer waiting
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input int s = 0);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (s == 0);
    forever begin
      @(posedge clk_i);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bready && s_axi_bvalid) begin
        bresp_q = s_axi_bresp;
        break;
      end
      if (s > 0) s--;
      if (s == 0) s_axi_bready <= 1'b1;
    end
    s_axi_bready <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] d, input int s = 0);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (s == 0);
    forever begin
      @(posedge clk_i);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rready && s_axi_rvalid) break;
      if (s > 0) s--;
      if (s == 0) s_axi_rready <= 1'b1;
    end
    d = s_axi_rdata;
    rresp_q = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rc(input logic [5:0] a, input logic [31:0] ex, input string nm);
    logic [31:0] d;
    rd(a, d, 3);
    `CHK(nm, ex, d)
  endtask
  // window of w clocks on the load model
  task automatic meas(input int w, input logic [15:0] ep, input logic [15:0] en);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    repeat (w) @(posedge clk_i);
    #1;
    `CHK("true output high time", ep, hi_p)
    `CHK("complement high time", en, hi_n)
    @(posedge clk_i);
  endtask
  // mode, compare, dead, window, true high, complement high
  int cfg [3][6] = '{'{0, 4, 2, 100, 10, 30}, '{1, 4, 2, 180, 40, 80}, '{2, 0, 0, 100, 0, 100}};
  initial begin
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    rc(`TPU_OFS_CTRL, 32'h0, "control at reset");
    rc(`TPU_OFS_PERIOD, 32'hffff, "period at reset");
    rc(`TPU_OFS_CMP, 32'h8000, "compare at reset");
    rc(6'h2c, 32'h0, "unmapped read");
    `CHK("unmapped read resp", `TPU_RESP_SLVERR, rresp_q)
    wr(6'h30, 32'h1, 6);
    `CHK("unmapped write resp", `TPU_RESP_SLVERR, bresp_q)
    wr(`TPU_OFS_CMP, 32'h8000);
    `CHK("mapped write resp", `TPU_RESP_OKAY, bresp_q)
    wr(`TPU_OFS_COUNT, 32'h1234);
    repeat (10) @(posedge clk_i);
    rc(`TPU_OFS_COUNT, 32'h1234, "stopped count");
    wr(`TPU_OFS_CTRL, 32'h30);
    capture_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    capture_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    rc(`TPU_OFS_CAPTURE, 32'h1234, "captured count");
    rd(`TPU_OFS_STATUS, c1);
    `CHK("capture flag", 1'b1, c1[`TPU_EV_CAP])
    wr(`TPU_OFS_INT_EN, 32'h4);
    repeat (2) @(posedge clk_i);
    `CHK("irq raised", 1'b1, irq_o)
    wr(`TPU_OFS_INT_EN, 32'h0);
    repeat (2) @(posedge clk_i);
    `CHK("irq masked", 1'b0, irq_o)
    wr(`TPU_OFS_INT_EN, 32'h4);
    wr(`TPU_OFS_INT_CLR, 32'h4);
    repeat (2) @(posedge clk_i);
    `CHK("irq cleared", 1'b0, irq_o)
    // reads are taken 3 edges apart, so the gaps below are 40 and 10 edges
    wr(`TPU_OFS_DIV, 32'h3);
    wr(`TPU_OFS_COUNT, 32'h0);
    wr(`TPU_OFS_CTRL, 32'h1);
    rd(`TPU_OFS_COUNT, c1);
    repeat (37) @(posedge clk_i);
    rd(`TPU_OFS_COUNT, c2);
    `CHK("divided count rate", 32'd10, c2 - c1)
    wr(`TPU_OFS_CTRL, 32'h0);
    wr(`TPU_OFS_PERIOD, 32'h9);
    wr(`TPU_OFS_DIV, 32'h0);
    wr(`TPU_OFS_COUNT, 32'h0);
    wr(`TPU_OFS_CTRL, 32'h1);
    rd(`TPU_OFS_COUNT, c1);
    repeat (7) @(posedge clk_i);
    rd(`TPU_OFS_COUNT, c2);
    `CHK("reload period", c1, c2)
    wr(`TPU_OFS_CTRL, 32'h3);
    repeat (20) @(posedge clk_i);
    rc(`TPU_OFS_CTRL, 32'h2, "one shot stopped");
    rc(`TPU_OFS_COUNT, 32'h9, "one shot count");
    rd(`TPU_OFS_STATUS, c1);
    `CHK("terminal flag", 1'b1, c1[`TPU_EV_TC])
    for (int i = 0; i < 3; i++) begin
      wr(`TPU_OFS_CTRL, 32'h0);
      wr(`TPU_OFS_CMP, cfg[i][1]);
      wr(`TPU_OFS_DEAD, cfg[i][2]);
      wr(`TPU_OFS_COUNT, 32'h0);
      wr(`TPU_OFS_CTRL, (cfg[i][0] << 2) | 1);
      repeat (40) @(posedge clk_i);
      meas(cfg[i][3], 16'(cfg[i][4]), 16'(cfg[i][5]));
    end
    // safe levels opposite to the live levels (compare is 0), so a missed kill shows
    wr(`TPU_OFS_CTRL, 32'h181);
    kill_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    meas(20, 16'd20, 16'd0);
    rd(`TPU_OFS_STATUS, c1);
    `CHK("kill flag", 1'b1, c1[`TPU_EV_KILL])
    kill_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    wr(`TPU_OFS_CTRL, 32'h141);
    comp_out_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    meas(20, 16'd20, 16'd0);
    comp_out_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    wr(`TPU_OFS_CTRL, 32'h0);
    stop_test;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      stop_test;
    end
  end
endmodule
`default_nettype wire
